// File: rtl/gpio_pkg.sv
// Purpose : Shared constants for the configurable GPIO port block
// Assumes : 8 pins per port, one 32-bit register word per offset
// Notes   : Each port owns a 0x40-byte window of registers
package gpio_pkg;

    // ------------------------------------------------------------
    // Geometry
    // ------------------------------------------------------------
    localparam int PINS_PER_PORT     = 8;
    localparam int PORT_WINDOW_SHIFT = 6;                // 0x40 bytes per port

    // ------------------------------------------------------------
    // Register offsets inside one port window
    // ------------------------------------------------------------
    localparam logic [5:0] OFF_OUT_DATA  = 6'h00;        // Output data
    localparam logic [5:0] OFF_PIN_STATE = 6'h04;        // Pin level, read only
    localparam logic [5:0] OFF_DRIVE     = 6'h08;        // 3 bits of drive mode per pin
    localparam logic [5:0] OFF_PAD_CFG   = 6'h0c;        // Disables, threshold, slew
    localparam logic [5:0] OFF_SIG_SEL   = 6'h10;        // Signal matrix, 2 bits per pin
    localparam logic [5:0] OFF_EDGE_CFG  = 6'h14;        // Interrupt edge, 2 bits per pin
    localparam logic [5:0] OFF_INT_STAT  = 6'h18;        // Sticky flags, write one to clear
    localparam logic [5:0] OFF_INT_MASK  = 6'h1c;        // Interrupt enables

    // ------------------------------------------------------------
    // Pad configuration field positions
    // ------------------------------------------------------------
    localparam int PAD_IN_DIS_POS  = 0;
    localparam int PAD_OUT_DIS_POS = 8;
    localparam int PAD_LVTTL_POS   = 16;
    localparam int PAD_SLEW_POS    = 24;

    // ------------------------------------------------------------
    // Encodings
    // ------------------------------------------------------------
    typedef enum logic [2:0]
    {
        DM_INPUT_ONLY   = 3'b000,
        DM_WEAKUP_STRDN = 3'b001,
        DM_STRUP_WEAKDN = 3'b010,
        DM_OD_LOW       = 3'b011,
        DM_OD_HIGH      = 3'b100,
        DM_STRONG       = 3'b101,
        DM_DISABLED     = 3'b110,
        DM_WEAK_BOTH    = 3'b111
    } drive_mode_e;

    typedef enum logic [1:0]
    {
        EDGE_NONE = 2'b00,
        EDGE_RISE = 2'b01,
        EDGE_FALL = 2'b10,
        EDGE_BOTH = 2'b11
    } edge_sel_e;

    localparam logic [1:0] SIG_GPIO    = 2'b00;          // Port data register drives pin
    localparam logic [1:0] RESP_OKAY   = 2'b00;
    localparam logic [1:0] RESP_SLVERR = 2'b10;

    // ------------------------------------------------------------
    // Reset values
    // ------------------------------------------------------------
    localparam logic [7:0]  RST_OUT_DATA = 8'h00;
    localparam logic [23:0] RST_DRIVE    = {8{DM_DISABLED}};
    localparam logic [31:0] RST_PAD_CFG  = 32'h0000_0000;
    localparam logic [15:0] RST_SIG_SEL  = 16'h0000;
    localparam logic [15:0] RST_EDGE_CFG = 16'h0000;
    localparam logic [7:0]  RST_INT      = 8'h00;

endpackage : gpio_pkg

// File: rtl/gpio_pin_cell.sv
// Purpose : One pad: drive-mode decode, hold retention, input sampling
// Assumes : Pad input synchronous to aclk; drivers resolved outside
// Notes   : All outputs are flops so held values truly stay fixed
`timescale 1ns/1ps
module gpio_pin_cell
    import gpio_pkg::*;
(
    input  wire logic       aclk,
    input  wire logic       aresetn,
    input  wire logic       ce,
    input  wire logic       hold,
    input  wire logic [2:0] mode,
    input  wire logic       data,
    input  wire logic       out_dis,
    input  wire logic       in_dis,
    input  wire logic       lvttl,
    input  wire logic       slew,
    input  wire logic       pad_in,
    output logic            pad_out,
    output logic            pad_oe_n,
    output logic            pull_up,
    output logic            pull_down,
    output logic            in_en,
    output logic            thresh_lvttl,
    output logic            slew_slow,
    output logic            level
);

    // ------------------------------------------------------------
    // Drive decode
    // ------------------------------------------------------------
    // Strong high/low and weak pull terms per mode and data bit
    wire logic strong_hi = data && (mode == DM_STRUP_WEAKDN || mode == DM_OD_HIGH || mode == DM_STRONG);
    wire logic strong_lo = !data && (mode == DM_WEAKUP_STRDN || mode == DM_OD_LOW || mode == DM_STRONG);
    wire logic weak_hi   = data && (mode == DM_WEAKUP_STRDN || mode == DM_WEAK_BOTH);
    wire logic weak_lo   = !data && (mode == DM_STRUP_WEAKDN || mode == DM_WEAK_BOTH);
    wire logic drv       = (strong_hi || strong_lo) && !out_dis;
    wire logic next_in   = !in_dis && (mode != DM_DISABLED);

    // ------------------------------------------------------------
    // Output flops; reset forces disabled, hold freezes drive
    // ------------------------------------------------------------
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            pad_out      <= 1'b0;
            pad_oe_n     <= 1'b1;
            pull_up      <= 1'b0;
            pull_down    <= 1'b0;
            in_en        <= 1'b0;
            thresh_lvttl <= 1'b0;
            slew_slow    <= 1'b0;
            level        <= 1'b0;
        end
        else if (ce)
        begin
            if (!hold)
            begin
                pad_out      <= strong_hi;
                pad_oe_n     <= !drv;
                pull_up      <= weak_hi && !out_dis;
                pull_down    <= weak_lo && !out_dis;
                in_en        <= next_in;
                thresh_lvttl <= lvttl;
                slew_slow    <= slew;
            end
            level <= pad_in && next_in;                  // Disabled input reads zero
        end
    end

endmodule : gpio_pin_cell

// File: rtl/gpio_port.sv
// Purpose : Multi-port GPIO block with AXI4-Lite registers and pin interrupts
// Assumes : All inputs synchronous to aclk; pads resolve pad_out/pad_oe_n/pulls
// Notes   : Each port owns a 0x40-byte register window of eight pins
//
// Chosen here: the AXI4-Lite interface to the registers and the placing of the registers.
`timescale 1ns/1ps
module gpio_port
    import gpio_pkg::*;
#(
    parameter int                NUM_PINS   = 21,
    parameter int                NUM_PORTS  = 3,
    parameter int                ADDR_W     = 8,
    parameter logic [NUM_PINS-1:0] FIXED_MASK = '0
)
(
    input  wire logic                aclk,
    input  wire logic                aresetn,
    input  wire logic                ce,
    input  wire logic                sleep_hold,
    input  wire logic [ADDR_W-1:0]   awaddr,
    input  wire logic                awvalid,
    output logic                     awready,
    input  wire logic [31:0]         wdata,
    input  wire logic [3:0]          wstrb,
    input  wire logic                wvalid,
    output logic                     wready,
    output logic [1:0]               bresp,
    output logic                     bvalid,
    input  wire logic                bready,
    input  wire logic [ADDR_W-1:0]   araddr,
    input  wire logic                arvalid,
    output logic                     arready,
    output logic [31:0]              rdata,
    output logic [1:0]               rresp,
    output logic                     rvalid,
    input  wire logic                rready,
    input  wire logic [NUM_PINS-1:0] periph_out_a,
    input  wire logic [NUM_PINS-1:0] periph_out_b,
    input  wire logic [NUM_PINS-1:0] periph_out_c,
    input  wire logic [NUM_PINS-1:0] fixed_out,
    input  wire logic [NUM_PINS-1:0] pad_in,
    output logic [NUM_PINS-1:0]      pad_out,
    output logic [NUM_PINS-1:0]      pad_oe_n,
    output logic [NUM_PINS-1:0]      pull_up,
    output logic [NUM_PINS-1:0]      pull_down,
    output logic [NUM_PINS-1:0]      in_en,
    output logic [NUM_PINS-1:0]      thresh_lvttl,
    output logic [NUM_PINS-1:0]      slew_slow,
    output logic [NUM_PINS-1:0]      pin_level,
    output logic [NUM_PORTS-1:0]     irq_port,
    output logic                     irq
);
    localparam int NS = NUM_PORTS * PINS_PER_PORT;       // Register slots; unused tail bits of config registers stay writable, pin state and interrupt status read zero there

    // ------------------------------------------------------------
    // Elaboration checks
    // ------------------------------------------------------------
    if (NUM_PINS > NS || NUM_PINS < 1)
        $error("gpio_port: NUM_PINS does not fit NUM_PORTS ports of 8 pins");
    if ((NUM_PORTS << PORT_WINDOW_SHIFT) > (1 << ADDR_W))
        $error("gpio_port: ADDR_W too narrow for the port windows");

    // ------------------------------------------------------------
    // Decode helpers, used by both read and write paths
    // ------------------------------------------------------------
    function automatic logic addr_hit(input logic [ADDR_W-1:0] a);
        logic [5:0] off;
        off = a[5:0];
        addr_hit = ((a >> PORT_WINDOW_SHIFT) < NUM_PORTS) && (off[1:0] == 2'b00) &&
                   (off <= OFF_INT_MASK);
    endfunction : addr_hit
    function automatic int addr_port(input logic [ADDR_W-1:0] a);
        addr_port = int'(a >> PORT_WINDOW_SHIFT);
    endfunction : addr_port

    // ------------------------------------------------------------
    // Register state, one window per port
    // ------------------------------------------------------------
    logic [NS-1:0]   out_data;
    logic [3*NS-1:0] drive;
    logic [NS-1:0]   in_dis;
    logic [NS-1:0]   out_dis;
    logic [NS-1:0]   lvttl;
    logic [NS-1:0]   slew;
    logic [2*NS-1:0] sig_sel;
    logic [2*NS-1:0] edge_cfg;
    logic [NS-1:0]   int_stat;
    logic [NS-1:0]   int_mask;
    logic [NS-1:0]   prev_level;
    logic [NUM_PORTS-1:0] held;
    logic [ADDR_W-1:0] wr_addr;
    logic [31:0]       wr_data;
    logic [3:0]        wr_strb;
    logic              aw_have;
    logic              w_have;
    wire logic [NS-1:0] level_slots = NS'(pin_level);

    // ------------------------------------------------------------
    // Register view of one port at one offset
    // ------------------------------------------------------------
    function automatic logic [31:0] reg_word(input int p, input logic [5:0] off);
        reg_word = 32'h0000_0000;
        case (off)
            OFF_OUT_DATA:  reg_word[7:0]  = out_data[p*8 +: 8];
            OFF_PIN_STATE: reg_word[7:0]  = level_slots[p*8 +: 8];
            OFF_DRIVE:     reg_word[23:0] = drive[p*24 +: 24];
            OFF_PAD_CFG:   reg_word       = {slew[p*8 +: 8], lvttl[p*8 +: 8], out_dis[p*8 +: 8],
                                             in_dis[p*8 +: 8]};
            OFF_SIG_SEL:   reg_word[15:0] = sig_sel[p*16 +: 16];
            OFF_EDGE_CFG:  reg_word[15:0] = edge_cfg[p*16 +: 16];
            OFF_INT_STAT:  reg_word[7:0]  = int_stat[p*8 +: 8];
            OFF_INT_MASK:  reg_word[7:0]  = int_mask[p*8 +: 8];
            default:       reg_word       = 32'h0000_0000;
        endcase
    endfunction : reg_word

    // ------------------------------------------------------------
    // Write path decode; byte strobes merge into the current word
    // ------------------------------------------------------------
    wire logic        wr_fire  = aw_have && w_have && !bvalid;
    wire logic        wr_hit   = addr_hit(wr_addr);
    wire integer      wr_port  = addr_port(wr_addr);
    wire logic [5:0]  wr_off   = wr_addr[5:0];
    wire logic [31:0] strb_msk = {{8{wr_strb[3]}}, {8{wr_strb[2]}}, {8{wr_strb[1]}}, {8{wr_strb[0]}}};
    logic      [31:0] wr_merge;                          // In a process: register changes must re-trigger it
    wire logic        do_write = wr_fire && wr_hit;
    wire logic        cfg_wr   = do_write && (wr_off != OFF_INT_STAT) && (wr_off != OFF_PIN_STATE);

    // ------------------------------------------------------------
    // Interrupt events: edge detect on sampled pin levels
    // ------------------------------------------------------------
    logic [NS-1:0] edge_hit;
    logic [NS-1:0] clr_mask;
    always_comb
    begin
        edge_hit = '0;
        clr_mask = '0;
        wr_merge = (reg_word(wr_port, wr_off) & ~strb_msk) | (wr_data & strb_msk);
        for (int i = 0; i < NS; i++)
        begin
            edge_hit[i] = (edge_cfg[2*i] && level_slots[i] && !prev_level[i]) ||
                          (edge_cfg[2*i+1] && !level_slots[i] && prev_level[i]);
        end
        if (do_write && wr_off == OFF_INT_STAT)
            clr_mask[wr_port*8 +: 8] = wr_data[7:0] & strb_msk[7:0];
    end
    // Per-port request from enabled pending flags
    logic [NUM_PORTS-1:0] next_irq_port;
    always_comb
    begin
        for (int p = 0; p < NUM_PORTS; p++)
            next_irq_port[p] = |(int_stat[p*8 +: 8] & int_mask[p*8 +: 8]);
    end
    // ------------------------------------------------------------
    // Register file writes
    // ------------------------------------------------------------
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            out_data <= {NUM_PORTS{RST_OUT_DATA}};
            drive    <= {NUM_PORTS{RST_DRIVE}};
            {slew, lvttl, out_dis, in_dis} <= '0;
            sig_sel  <= {NUM_PORTS{RST_SIG_SEL}};
            edge_cfg <= {NUM_PORTS{RST_EDGE_CFG}};
            int_mask <= {NUM_PORTS{RST_INT}};
        end
        else if (ce && do_write)
        begin
            case (wr_off)
                OFF_OUT_DATA: out_data[wr_port*8 +: 8]  <= wr_merge[7:0];
                OFF_DRIVE:    drive[wr_port*24 +: 24]   <= wr_merge[23:0];
                OFF_PAD_CFG:
                begin
                    in_dis[wr_port*8 +: 8]  <= wr_merge[PAD_IN_DIS_POS +: 8];
                    out_dis[wr_port*8 +: 8] <= wr_merge[PAD_OUT_DIS_POS +: 8];
                    lvttl[wr_port*8 +: 8]   <= wr_merge[PAD_LVTTL_POS +: 8];
                    slew[wr_port*8 +: 8]    <= wr_merge[PAD_SLEW_POS +: 8];
                end
                OFF_SIG_SEL:  sig_sel[wr_port*16 +: 16]  <= wr_merge[15:0];
                OFF_EDGE_CFG: edge_cfg[wr_port*16 +: 16] <= wr_merge[15:0];
                OFF_INT_MASK: int_mask[wr_port*8 +: 8]   <= wr_merge[7:0];
                default:      ;
            endcase
        end
    end
    // Sticky flags: a new edge wins over a clear in the same cycle
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            int_stat   <= {NUM_PORTS{RST_INT}};
            prev_level <= '0;
            irq_port   <= '0;
            irq        <= 1'b0;
        end
        else if (ce)
        begin
            int_stat   <= (int_stat & ~clr_mask) | edge_hit;
            prev_level <= level_slots;
            irq_port   <= next_irq_port;
            irq        <= |next_irq_port;
        end
    end
    // Hold per port: armed by sleep, released only by a config write or by reset
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
            held <= '0;
        else if (ce)
        begin
            for (int p = 0; p < NUM_PORTS; p++)
            begin
                if (sleep_hold)
                    held[p] <= 1'b1;
                else if (cfg_wr && wr_port == p)
                    held[p] <= 1'b0;
            end
        end
    end
    // ------------------------------------------------------------
    // AXI4-Lite write channel: address and data taken in any order
    // ------------------------------------------------------------
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            awready <= 1'b0;
            wready  <= 1'b0;
            aw_have <= 1'b0;
            w_have  <= 1'b0;
            bvalid  <= 1'b0;
            bresp   <= RESP_OKAY;
            wr_addr <= '0;
            wr_data <= 32'h0000_0000;
            wr_strb <= 4'h0;
        end
        else if (ce)
        begin
            awready <= !aw_have && !awready && awvalid;   // One-cycle ready pulse per beat
            wready  <= !w_have && !wready && wvalid;
            if (awvalid && awready)
            begin
                aw_have <= 1'b1;
                wr_addr <= awaddr;
            end
            if (wvalid && wready)
            begin
                w_have  <= 1'b1;
                wr_data <= wdata;
                wr_strb <= wstrb;
            end
            if (wr_fire)
            begin
                bvalid  <= 1'b1;
                bresp   <= wr_hit ? RESP_OKAY : RESP_SLVERR;
                aw_have <= 1'b0;
                w_have  <= 1'b0;
            end
            else if (bvalid && bready)
                bvalid <= 1'b0;
        end
    end
    // ------------------------------------------------------------
    // AXI4-Lite read channel: answer one cycle after address taken
    // ------------------------------------------------------------
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            arready <= 1'b0;
            rvalid  <= 1'b0;
            rdata   <= 32'h0000_0000;
            rresp   <= RESP_OKAY;
        end
        else if (ce)
        begin
            arready <= !rvalid && !arready && arvalid;
            if (arvalid && arready)
            begin
                rvalid <= 1'b1;
                rdata  <= addr_hit(araddr) ? reg_word(addr_port(araddr), araddr[5:0]) : 32'h0000_0000;
                rresp  <= addr_hit(araddr) ? RESP_OKAY : RESP_SLVERR;
            end
            else if (rvalid && rready)
                rvalid <= 1'b0;
        end
    end

    // ------------------------------------------------------------
    // Pin cells: signal matrix selects each pin's data source, FIXED_MASK pins take fixed_out
    // ------------------------------------------------------------
    for (genvar i = 0; i < NUM_PINS; i++)
    begin : g_pin
        wire logic [1:0] sel = sig_sel[2*i +: 2];
        wire logic       src = FIXED_MASK[i] ? fixed_out[i] :
                               (sel == SIG_GPIO) ? out_data[i] :
                               (sel == 2'b01) ? periph_out_a[i] :
                               (sel == 2'b10) ? periph_out_b[i] : periph_out_c[i];
        gpio_pin_cell u_cell
        (
            .aclk         (aclk),
            .aresetn      (aresetn),
            .ce           (ce),
            .hold         (held[i / PINS_PER_PORT]),
            .mode         (drive[3*i +: 3]),
            .data         (src),
            .out_dis      (out_dis[i]),
            .in_dis       (in_dis[i]),
            .lvttl        (lvttl[i]),
            .slew         (slew[i]),
            .pad_in       (pad_in[i]),
            .pad_out      (pad_out[i]),
            .pad_oe_n     (pad_oe_n[i]),
            .pull_up      (pull_up[i]),
            .pull_down    (pull_down[i]),
            .in_en        (in_en[i]),
            .thresh_lvttl (thresh_lvttl[i]),
            .slew_slow    (slew_slow[i]),
            .level        (pin_level[i])
        );
    end
endmodule : gpio_port

// File: tb/gpio_port_assertions.sv
// Purpose : Port-level checks for the GPIO port block
// Assumes : One aclk domain, synchronous active-low reset
// Notes   : Sees the top module's ports only
`timescale 1ns/1ps
module gpio_port_assertions #(
    parameter int NUM_PINS  = 21,
    parameter int NUM_PORTS = 3
)(
    input wire logic                 aclk,
    input wire logic                 aresetn,
    input wire logic                 awvalid,
    input wire logic                 awready,
    input wire logic                 wvalid,
    input wire logic                 wready,
    input wire logic [1:0]           bresp,
    input wire logic                 bvalid,
    input wire logic                 bready,
    input wire logic                 arvalid,
    input wire logic                 arready,
    input wire logic [31:0]          rdata,
    input wire logic                 rvalid,
    input wire logic                 rready,
    input wire logic [NUM_PINS-1:0]  pad_oe_n,
    input wire logic [NUM_PINS-1:0]  pull_up,
    input wire logic [NUM_PINS-1:0]  in_en,
    input wire logic [NUM_PINS-1:0]  pin_level,
    input wire logic [NUM_PORTS-1:0] irq_port,
    input wire logic                 irq
);
    default clocking @(posedge aclk); endclocking
    default disable iff (!aresetn);
    // Bus steps
    sequence aw_w_taken; awvalid && awready && wvalid && wready; endsequence
    sequence ar_taken; arvalid && arready; endsequence
    // Reset itself must float the pins, so this one is never disabled
    reset_hiz_a: assert property (disable iff (1'b0) !aresetn |=> &pad_oe_n && !(|pull_up))
        else $error("pins driven during reset");
    write_answer_a: assert property (aw_w_taken |-> ##2 bvalid)
        else $error("write answer late");
    read_answer_a: assert property (ar_taken |=> rvalid)
        else $error("read answer late");
    bresp_hold_a: assert property (bvalid && !bready |=> bvalid && $stable(bresp))
        else $error("write response dropped");
    rdata_hold_a: assert property (rvalid && !rready |=> rvalid && $stable(rdata))
        else $error("read data dropped");
    aw_pulse_a: assert property (awready |=> !awready)
        else $error("awready longer than a pulse");
    ar_pulse_a: assert property (arready |=> !arready)
        else $error("arready longer than a pulse");
    irq_combine_a: assert property (irq_port == '0 [*2] |-> !irq)
        else $error("irq without port request");
    level_gate_a: assert property (!in_en[0] [*2] |-> !pin_level[0])
        else $error("level seen with input off");
endmodule : gpio_port_assertions

// File: tb/pad_model.sv
// Purpose : Board side of the pads: strong drive, pulls, else external level
// Assumes : Weak pulls lose to a strong driver
// Notes   : A floating pin shows ext_level, which the bench controls
`timescale 1ns/1ps
module pad_model #(parameter int N = 21)(
    input  wire logic [N-1:0] pad_out,
    input  wire logic [N-1:0] pad_oe_n,
    input  wire logic [N-1:0] pull_up,
    input  wire logic [N-1:0] pull_down,
    input  wire logic [N-1:0] ext_level,
    output logic      [N-1:0] pad_in
);
    // Strong drive first, then pulls, then the outside world
    assign pad_in = (~pad_oe_n & pad_out) | (pad_oe_n & (pull_up | (~pull_down & ext_level)));
endmodule : pad_model

// File: tb/tb.sv
// Purpose : Self-checking bench for the GPIO port block
// Assumes : AXI4-Lite master tasks, pads looped through pad_model
// Notes   : Fixed waits cover register-to-pad and pin-to-irq latency
`timescale 1ns/1ps
module tb;
    import gpio_pkg::*;
    logic aclk = 0, aresetn = 0, ce = 1, sleep_hold = 0;
    logic [7:0] awaddr = 0, araddr = 0;
    logic [31:0] wdata = 0, rdata, rd_v;
    logic [3:0] wstrb = 4'hf;
    logic awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
    logic awready, wready, bvalid, arready, rvalid, irq;
    logic [1:0] bresp, rresp, rd_r, wr_r;
    logic [20:0] periph_out_a = 21'h0f, periph_out_b = 21'h3c, periph_out_c = 21'hf0;
    logic [20:0] fixed_out = 21'h100000, ext_level = 0, pad_in, pad_out, pad_oe_n, pull_up, pull_down;
    logic [20:0] in_en, thresh_lvttl, slew_slow, pin_level;
    logic [2:0] irq_port;
    int miscompares = 0, checked = 0;
    gpio_port #(.FIXED_MASK(21'h100000)) i_dut (.*);
    pad_model i_pads (.*);
    always #20 aclk = ~aclk;
    task chk(input string n, input logic [31:0] e, input logic [31:0] g);
        checked++;
        if (g !== e)
        begin
            miscompares++;
            $display("MISMATCH %s expected %h seen %h", n, e, g);
        end
    endtask : chk
    // Both write channels offered together; bready waits up for the answer
    task wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge aclk);
        awaddr <= a; wdata <= d; awvalid <= 1; wvalid <= 1; bready <= 1;
        do begin @(posedge aclk); if (awready) awvalid <= 0; if (wready) wvalid <= 0; end while (!bvalid);
        wr_r = bresp; bready <= 0;
    endtask : wr
    task rd(input logic [7:0] a);
        @(posedge aclk);
        araddr <= a; arvalid <= 1; rready <= 1;
        do begin @(posedge aclk); if (arready) arvalid <= 0; end while (!rvalid);
        rd_v = rdata; rd_r = rresp; rready <= 0;
    endtask : rd
    task rc(input logic [7:0] a, input logic [31:0] e);
        rd(a);
        chk("reg_read", e, rd_v);
    endtask : rc
    task settle;
        repeat (6) @(posedge aclk);
    endtask : settle
    task results;
        $display("checked %0d miscompares %0d", checked, miscompares);
        if (miscompares == 0 && checked > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask : results
    initial
    begin
        #400000;
        miscompares++;
        results;
    end
    initial
    begin
        repeat (6) @(posedge aclk);
        aresetn <= 1;
        chk("oe_reset", 32'h1fffff, pad_oe_n);
        rc(OFF_DRIVE, 32'h00db6db6);
        // Pin 0 carries data 1, pin 1 data 0, through every drive mode
        wr(OFF_OUT_DATA, 1);
        for (int m = 0; m < 8; m++)
        begin
            wr(OFF_DRIVE, {8{m[2:0]}});
            settle;
            chk("mode", {1'(8'hd5 >> m), 1'(8'hcb >> m), 1'(8'h82 >> m), 1'(8'h84 >> m)},
                {pad_oe_n[1:0], pull_up[0], pull_down[1]});
        end
        wr(OFF_DRIVE, {8{3'd5}});
        wr(OFF_PAD_CFG, 32'h01010101);
        settle;
        chk("pad_cfg", 8'h95, {in_en[1:0], pad_oe_n[1:0], thresh_lvttl[1:0], slew_slow[1:0]});
        wr(OFF_PAD_CFG, 0);
        wr(OFF_OUT_DATA, 8'ha5);
        settle;
        rc(OFF_PIN_STATE, 32'ha5);
        for (int k = 1; k < 4; k++)
        begin
            wr(OFF_SIG_SEL, {8{k[1:0]}});
            settle;
            chk("matrix", k == 1 ? 8'h0f : k == 2 ? 8'h3c : 8'hf0, pad_out[7:0]);
        end
        wr(OFF_SIG_SEL, 0);
        wr(8'h88, {8{3'd5}});
        settle;
        chk("fixed_pin", 1, pad_out[20]);
        wr(8'h40, 8'h3c);
        rc(8'h40, 32'h3c);
        rc(OFF_OUT_DATA, 32'ha5);
        rd(8'hc0);
        chk("rresp", RESP_SLVERR, rd_r);
        wr(8'hc0, 1);
        chk("bresp", RESP_SLVERR, wr_r);
        // Rising edge on a floating input pin, then mask, clear, fall
        wr(OFF_DRIVE, 0);
        wr(OFF_EDGE_CFG, 1);
        wr(OFF_INT_MASK, 1);
        ext_level[0] <= 1;
        settle;
        chk("irq_set", 4'b0011, {irq_port, irq});
        rc(OFF_INT_STAT, 1);
        wr(OFF_INT_MASK, 0);
        settle;
        chk("irq_mask", 0, {irq_port, irq});
        wr(OFF_INT_STAT, 1);
        rc(OFF_INT_STAT, 0);
        wr(OFF_INT_MASK, 1);
        ext_level[0] <= 0;
        settle;
        chk("irq_fall", 0, {irq_port, irq});
        wr(OFF_EDGE_CFG, 2);
        ext_level[0] <= 1;
        settle;
        ext_level[0] <= 0;
        settle;
        chk("irq_fall_set", 4'b0011, {irq_port, irq});
        // Held drive survives a data write and the end of sleep
        wr(OFF_DRIVE, {8{3'd5}});
        wr(OFF_OUT_DATA, 1);
        sleep_hold <= 1;
        settle;
        wr(OFF_OUT_DATA, 0);
        settle;
        chk("hold", 1, pad_out[0]);
        sleep_hold <= 0;
        settle;
        chk("hold_wake", 1, pad_out[0]);
        wr(OFF_OUT_DATA, 0);
        settle;
        chk("hold_free", 0, pad_out[0]);
        wr(OFF_OUT_DATA, 1);
        sleep_hold <= 1;
        settle;
        aresetn <= 0;
        sleep_hold <= 0;
        repeat (6) @(posedge aclk);
        aresetn <= 1;
        settle;
        chk("oe_wake_rst", 32'h1fffff, pad_oe_n);
        results;
    end
endmodule : tb
bind gpio_port gpio_port_assertions #(.NUM_PINS(NUM_PINS), .NUM_PORTS(NUM_PORTS)) i_chk (.*);
